//--- core/stpsq_sequencer.sv
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/10ps
`include "stpsq_regs.svh"
// Functional notes
// (R01) Stop mode: prescaler cleared, clocks off
// (R02) Leave stop on interrupt, reset, break
// (R03) No stacking before recovery delay ends
// (R04) Gate bus and crystal clock outputs
// (R05) Delay 4096 cycles, or 32 if short
// (R06) Crystal systems should keep short bit clear
// (R07) Break wakeup from stop sets exit flag
// (R08) Prescaler held until recovery, then counts
// (R09) Writing zero clears break exit flag
// (R10) Exit flag reads one after break exit
// (R11) Reading reset cause clears all flags
// (R12) Power-on reset sets power-on flag
// (R13) Pin reset sets external reset flag
// (R14) Watchdog reset sets watchdog flag
// (R15) Illegal opcode reset sets its flag
// (R16) Illegal fetch address reset sets flag
// (R17) Low-voltage reset sets its flag
// (R18) Clear enable gates break-state flag clearing; only flag_clear_ok_out is gated, cause and exit flags clear regardless
// (R19) Twelve-bit prescaler on crystal falling phase
// (R20) Flag cleared in break stays cleared
// (R21) Recovery done re-enables clocks, then service
module stpsq_sequencer
	import stpsq_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        resetn_in,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [7:0]  avs_writedata_in,
	output logic      [7:0]  avs_readdata_out,
	output logic             avs_waitrequest_out,
	// CPU and wake sources
	input  wire logic        stop_exec_in,
	input  wire logic        irq_in,
	input  wire logic        break_in,
	input  wire logic        wake_reset_in,
	input  wire logic        break_state_in,
	// Reset causes, one-cycle pulses
	input  wire logic        por_event_in,
	input  wire logic        pin_reset_in,
	input  wire logic        wdog_reset_in,
	input  wire logic        illegal_opcode_flag_reset_in,
	input  wire logic        illegal_address_flag_fetch_in,
	input  wire logic        lvr_reset_in,
	// Clock gating and handshake
	output logic             bus_clock_en_out,
	output logic             crystal_clock_en_out,
	output logic             stack_go_out,
	output logic             flag_clear_ok_out,
	output logic      [11:0] prescaler_out
);
	// ==========================================
	// Bus decode
	stpsq_bus_req_t req;
	logic           ack;
	logic           rd_cause;
	logic           wr_hit;
	assign req = '{avs_read_in, avs_write_in, avs_address_in, avs_writedata_in};

	function automatic logic hit(input stpsq_bus_req_t r, input logic [3:0] a);
		hit = (r.read | r.write) && (r.address == a);
	endfunction

	// One wait cycle per access keeps reads with side effects single-shot
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			ack <= 1'b0;
		end else begin
			ack <= (req.read | req.write) & ~ack;
		end
	end
	assign avs_waitrequest_out = (req.read | req.write) & ~ack;
	// Clear at the capture edge, so a cause that arrives later is never lost unread
	assign rd_cause = req.read & ~ack & hit(req, `STPSQ_ADDR_RESET_CAUSE);
	assign wr_hit   = ack & req.write;

	// ==========================================
	// State and prescaler
	stpsq_state_t state;
	stpsq_state_t next_state;
	logic         short_recovery;
	logic         clear_enable;
	logic         break_exit;
	logic         phase;
	logic         fall_tick;
	logic         wake;
	logic [11:0]  limit;
	assign wake = irq_in | break_in | wake_reset_in; // [R02]
	assign limit = short_recovery ? `STPSQ_RECOVERY_SHORT : `STPSQ_RECOVERY_LONG; // [R05]
	assign fall_tick = (phase == `STPSQ_FALL_PHASE);

	// Crystal clock is modeled as sys_clk/2; its falling phase is an enable
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			phase <= 1'b0;
		end else begin
			phase <= ~phase;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			STPSQ_RUN: begin
				if (stop_exec_in) begin
					next_state = STPSQ_STOPPED;
				end
			end
			STPSQ_STOPPED: begin
				if (wake) begin
					next_state = STPSQ_RECOVER;
				end
			end
			STPSQ_RECOVER: begin
				if (fall_tick && prescaler_out == limit) begin
					next_state = STPSQ_RUN; // [R21]
				end
			end
			default: begin
				next_state = STPSQ_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			state <= STPSQ_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Counts outside stop, restarting from zero when recovery ends; doubles as watchdog prescaler
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			prescaler_out <= `STPSQ_CNT_ZERO;
		end else if (state == STPSQ_STOPPED || next_state == STPSQ_STOPPED) begin
			prescaler_out <= `STPSQ_CNT_ZERO; // [R01] [R08]
		end else if (state == STPSQ_RECOVER && next_state == STPSQ_RUN) begin
			prescaler_out <= `STPSQ_CNT_ZERO;
		end else if (fall_tick) begin
			prescaler_out <= prescaler_out + `STPSQ_CNT_ONE; // [R19] [R08]
		end
	end

	assign bus_clock_en_out     = (state == STPSQ_RUN); // [R04] [R21]
	assign crystal_clock_en_out = (state != STPSQ_STOPPED); // [R04] [R01]

	// Stacking released only when recovery completes
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			stack_go_out <= 1'b0;
		end else begin
			stack_go_out <= (state == STPSQ_RECOVER) && (next_state == STPSQ_RUN); // [R03]
		end
	end

	// ==========================================
	// Control registers
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			short_recovery <= 1'b0; // [R06]
			clear_enable   <= 1'b0;
		end else if (wr_hit) begin
			if (hit(req, `STPSQ_ADDR_CONFIG)) begin
				short_recovery <= req.writedata[`STPSQ_BIT_SHORT_RECOVERY];
			end
			if (hit(req, `STPSQ_ADDR_BREAK_FLAG_CTL)) begin
				clear_enable <= req.writedata[`STPSQ_BIT_CLEAR_ENABLE];
			end
		end
	end
	assign flag_clear_ok_out = ~break_state_in | clear_enable; // [R18] [R20]

	// Set wins over a simultaneous software clear
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			break_exit <= 1'b0;
		end else if (state == STPSQ_STOPPED && break_in) begin
			break_exit <= 1'b1; // [R07] [R10]
		end else if (wr_hit && req.address == `STPSQ_ADDR_BREAK_STATUS
				&& !req.writedata[`STPSQ_BIT_BREAK_EXIT]) begin
			break_exit <= 1'b0; // [R09]
		end
	end

	// ==========================================
	// Reset cause; por starts set since sys reset models power-on
	stpsq_cause_t cause;
	stpsq_cause_t set_cause;
	assign set_cause = '{por_event_in, pin_reset_in, wdog_reset_in, illegal_opcode_flag_reset_in,
		illegal_address_flag_fetch_in, lvr_reset_in}; // [R12] [R13] [R14] [R15] [R16] [R17]

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			cause <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}; // [R12]
		end else if (|set_cause) begin
			cause <= set_cause; // [R13] [R14] [R15] [R16] [R17]
		end else if (rd_cause) begin
			cause <= '0; // [R11]
		end
	end

	// ==========================================
	// Read data
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			avs_readdata_out <= `STPSQ_RST_BYTE;
		end else if ((req.read & ~ack) == 1'b1) begin
			avs_readdata_out <= `STPSQ_RST_BYTE;
			case (req.address)
				`STPSQ_ADDR_BREAK_STATUS: begin
					avs_readdata_out[`STPSQ_BIT_BREAK_EXIT] <= break_exit; // [R10]
				end
				`STPSQ_ADDR_RESET_CAUSE: begin
					avs_readdata_out[`STPSQ_BIT_POR]  <= cause.por;
					avs_readdata_out[`STPSQ_BIT_PIN]  <= cause.pin;
					avs_readdata_out[`STPSQ_BIT_WDOG] <= cause.wdog;
					avs_readdata_out[`STPSQ_BIT_ILLEGAL_OPCODE_FLAG] <= cause.illegal_opcode_flag;
					avs_readdata_out[`STPSQ_BIT_ILLEGAL_ADDRESS_FLAG] <= cause.illegal_address_flag;
					avs_readdata_out[`STPSQ_BIT_LVR]  <= cause.lvr;
				end
				`STPSQ_ADDR_BREAK_FLAG_CTL: begin
					avs_readdata_out[`STPSQ_BIT_CLEAR_ENABLE] <= clear_enable;
				end
				`STPSQ_ADDR_CONFIG: begin
					avs_readdata_out[`STPSQ_BIT_SHORT_RECOVERY] <= short_recovery;
				end
				`STPSQ_ADDR_STATE: begin
					avs_readdata_out[1:0] <= state;
				end
				default: begin
					avs_readdata_out <= `STPSQ_RST_BYTE;
				end
			endcase
		end
	end

	// ==========================================
	// Checks
	property p_stop_clocks;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_STOPPED |-> !bus_clock_en_out && !crystal_clock_en_out;
	endproperty
	a_stop_clocks: assert property (p_stop_clocks) else $error("clocks on in stop"); // [R04]

	property p_stop_cnt;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_STOPPED |=> prescaler_out == `STPSQ_CNT_ZERO || state == STPSQ_RECOVER;
	endproperty
	a_stop_cnt: assert property (p_stop_cnt) else $error("prescaler not held"); // [R01]

	property p_wake;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_STOPPED && wake |=> state == STPSQ_RECOVER;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake"); // [R02]

	property p_short;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		$rose(state == STPSQ_RECOVER) && short_recovery |-> ##[63:66] state == STPSQ_RUN;
	endproperty
	a_short: assert property (p_short) else $error("short delay wrong"); // [R05]

	property p_stack;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		stack_go_out |-> $past(state) == STPSQ_RECOVER && bus_clock_en_out;
	endproperty
	a_stack: assert property (p_stack) else $error("early stacking"); // [R03]

	property p_brk;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_STOPPED && break_in |=> break_exit;
	endproperty
	a_brk: assert property (p_brk) else $error("break flag not set"); // [R07]

	property p_rc;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		rd_cause && !(|set_cause) |=> cause == '0;
	endproperty
	a_rc: assert property (p_rc) else $error("cause not cleared"); // [R11]

	property p_break_flag_clear_enable;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		break_state_in && !clear_enable |-> !flag_clear_ok_out;
	endproperty
	a_break_flag_clear_enable: assert property (p_break_flag_clear_enable) else $error("flags unprotected"); // [R18]

	// System cycles spent in recovery; only the delay check reads it
	logic [12:0] rec_cnt;
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in || state != STPSQ_RECOVER) begin
			rec_cnt <= `STPSQ_REC_ZERO;
		end else begin
			rec_cnt <= rec_cnt + `STPSQ_REC_ONE;
		end
	end

	property p_rec_len;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_RECOVER && next_state == STPSQ_RUN |->
			rec_cnt[12:1] == (short_recovery ? `STPSQ_RECOVERY_SHORT : `STPSQ_RECOVERY_LONG);
	endproperty
	a_rec_len: assert property (p_rec_len) else $error("recovery length wrong"); // [R05]

	property p_presc_step;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_RECOVER && fall_tick && next_state == STPSQ_RECOVER |=>
			prescaler_out == $past(prescaler_out) + `STPSQ_CNT_ONE;
	endproperty
	a_presc_step: assert property (p_presc_step) else $error("prescaler not counting"); // [R08] [R19]

	property p_presc_hold;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_RECOVER && !fall_tick |=> $stable(prescaler_out);
	endproperty
	a_presc_hold: assert property (p_presc_hold) else $error("prescaler off its phase"); // [R19]

	property p_stop_entry;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_RUN && stop_exec_in |=> state == STPSQ_STOPPED && prescaler_out == `STPSQ_CNT_ZERO;
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop not entered"); // [R01] [R08]

	property p_stay_stop;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_STOPPED && !wake |=> state == STPSQ_STOPPED && !crystal_clock_en_out;
	endproperty
	a_stay_stop: assert property (p_stay_stop) else $error("left stop unasked"); // [R01]

	property p_rec_start;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		$rose(state == STPSQ_RECOVER) |-> prescaler_out == `STPSQ_CNT_ZERO;
	endproperty
	a_rec_start: assert property (p_rec_start) else $error("recovery count not from zero"); // [R08]

	property p_rec_clocks;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_RECOVER |-> !bus_clock_en_out && crystal_clock_en_out;
	endproperty
	a_rec_clocks: assert property (p_rec_clocks) else $error("clocks wrong in recovery"); // [R03] [R21]

	property p_no_stack;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state != STPSQ_RUN |-> !stack_go_out;
	endproperty
	a_no_stack: assert property (p_no_stack) else $error("stacking while halted"); // [R03]

	property p_rec_done;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		state == STPSQ_RECOVER && next_state == STPSQ_RUN |=> stack_go_out && bus_clock_en_out;
	endproperty
	a_rec_done: assert property (p_rec_done) else $error("no release after recovery"); // [R21]

	property p_exit_clr;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		wr_hit && hit(req, `STPSQ_ADDR_BREAK_STATUS)
			&& !req.writedata[`STPSQ_BIT_BREAK_EXIT]
			&& !(state == STPSQ_STOPPED && break_in) |=> !break_exit;
	endproperty
	a_exit_clr: assert property (p_exit_clr) else $error("exit flag not cleared"); // [R09]

	property p_exit_keep;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		break_exit && !(wr_hit && hit(req, `STPSQ_ADDR_BREAK_STATUS)) |=> break_exit;
	endproperty
	a_exit_keep: assert property (p_exit_keep) else $error("exit flag lost"); // [R10]

	property p_cause_set;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		|set_cause |=> cause == $past(set_cause);
	endproperty
	a_cause_set: assert property (p_cause_set) else $error("cause not recorded"); // [R13] [R14] [R15] [R16] [R17]

	property p_por;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		$rose(resetn_in) |-> cause.por && state == STPSQ_RUN && !stack_go_out;
	endproperty
	a_por: assert property (p_por) else $error("power-on state wrong"); // [R12]

	property p_break_flag_clear_enable_on;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		!break_state_in || clear_enable |-> flag_clear_ok_out;
	endproperty
	a_break_flag_clear_enable_on: assert property (p_break_flag_clear_enable_on) else $error("flag clearing blocked"); // [R18] [R20]
endmodule

//--- core/stpsq_regs.svh
`ifndef STPSQ_REGS_SVH
`define STPSQ_REGS_SVH
// ==========================================
// Register map (word addresses on the bus)
`define STPSQ_ADDR_BREAK_STATUS   4'h0
`define STPSQ_ADDR_RESET_CAUSE    4'h1
`define STPSQ_ADDR_BREAK_FLAG_CTL 4'h2
`define STPSQ_ADDR_CONFIG         4'h3
`define STPSQ_ADDR_STATE          4'h4
// ==========================================
// Field positions
`define STPSQ_BIT_BREAK_EXIT      1
`define STPSQ_BIT_CLEAR_ENABLE    0
`define STPSQ_BIT_SHORT_RECOVERY  0
`define STPSQ_BIT_LVR             1
`define STPSQ_BIT_ILLEGAL_ADDRESS_FLAG            3
`define STPSQ_BIT_ILLEGAL_OPCODE_FLAG            4
`define STPSQ_BIT_WDOG            5
`define STPSQ_BIT_PIN             6
`define STPSQ_BIT_POR             7
// ==========================================
// Reset values and timing
`define STPSQ_RST_BYTE            8'h00
`define STPSQ_RST_CAUSE_POR       8'h80
`define STPSQ_RECOVERY_LONG       12'hfff
`define STPSQ_RECOVERY_SHORT      12'h01f
`define STPSQ_CNT_ZERO            12'h000
`define STPSQ_CNT_ONE             12'h001
`define STPSQ_REC_ZERO            13'h0000
`define STPSQ_REC_ONE             13'h0001
`define STPSQ_FALL_PHASE          1'b1
`endif

//--- core/stpsq_pkg.sv
package stpsq_pkg;
	typedef enum logic [1:0] {
		STPSQ_RUN     = 2'b00,
		STPSQ_STOPPED = 2'b01,
		STPSQ_RECOVER = 2'b10
	} stpsq_state_t;

	typedef struct packed {
		logic por;
		logic pin;
		logic wdog;
		logic illegal_opcode_flag;
		logic illegal_address_flag;
		logic lvr;
	} stpsq_cause_t;

	typedef struct packed {
		logic       read;
		logic       write;
		logic [3:0] address;
		logic [7:0] writedata;
	} stpsq_bus_req_t;
endpackage

//--- test/stpsq_cpu_model.sv
`timescale 1ns/10ps
module stpsq_cpu_model (
	// Clock, reset and command
	input  wire logic       sys_clk_in,
	input  wire logic       resetn_in,
	input  wire logic       go_in,
	input  wire logic [1:0] kind_in,
	// Toward the sequencer
	output logic            stop_exec_out,
	output logic            irq_out,
	output logic            break_out,
	output logic            wake_reset_out
);
	logic [3:0] delay;
	logic       armed;
	// ==========================================
	// STOP, then one wake pulse after a random pause; kind 3 sends none
	always_ff @(posedge sys_clk_in) begin
		stop_exec_out <= 1'b0;
		{irq_out, break_out, wake_reset_out} <= 3'h0;
		if (!resetn_in) begin
			armed <= 1'b0;
			delay <= 4'h0;
		end else if (go_in) begin
			stop_exec_out <= 1'b1;
			armed         <= 1'b1;
			delay         <= 4'(3 + $urandom % 12);
		end else if (armed) begin
			delay <= delay - 4'h1;
			if (delay == 4'h0) begin
				// One-cycle pulse is the weakest legal wake request
				armed <= 1'b0;
				{irq_out, break_out, wake_reset_out} <= 3'h4 >> kind_in;
			end
		end
	end
endmodule

//--- test/test_stop_mode_and_reset_status.sv
`timescale 1ns/10ps
module test_stop_mode_and_reset_status;
	import stpsq_pkg::*;
	logic sys_clk, resetn, go, brk_state, stop_exec, irq, brk, wake_rst;
	logic bus_en, xtal_en, stack_go, clr_ok, waitreq;
	logic [1:0] kind;
	logic [7:0] rdata;
	logic [11:0] presc;
	stpsq_bus_req_t req;
	stpsq_cause_t cause;
	logic [7:0] expq[$];
	int error_cnt, comparisons;
	stpsq_sequencer stpsq_sequencer_inst (.sys_clk_in(sys_clk), .resetn_in(resetn),
		.avs_address_in(req.address), .avs_read_in(req.read), .avs_write_in(req.write),
		.avs_writedata_in(req.writedata), .avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq), .stop_exec_in(stop_exec), .irq_in(irq),
		.break_in(brk), .wake_reset_in(wake_rst), .break_state_in(brk_state),
		.por_event_in(cause.por), .pin_reset_in(cause.pin), .wdog_reset_in(cause.wdog),
		.illegal_opcode_flag_reset_in(cause.illegal_opcode_flag), .illegal_address_flag_fetch_in(cause.illegal_address_flag), .lvr_reset_in(cause.lvr),
		.bus_clock_en_out(bus_en), .crystal_clock_en_out(xtal_en),
		.stack_go_out(stack_go), .flag_clear_ok_out(clr_ok), .prescaler_out(presc));
	stpsq_cpu_model stpsq_cpu_model_inst (.sys_clk_in(sys_clk), .resetn_in(resetn),
		.go_in(go), .kind_in(kind), .stop_exec_out(stop_exec), .irq_out(irq),
		.break_out(brk), .wake_reset_out(wake_rst));
	// ==========================================
	// Checking and closing
	task test_done;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk1(input logic g, input logic e, input string m);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t %s got %b exp %b", $time, m, g, e);
		end
	endtask
	task chk8(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t readdata got %h exp %h", $time, g, e);
		end
	endtask
	task limit(input int c, input int l);
		if (c >= l) begin
			error_cnt++;
			$display("MISMATCH %0t wait ran out", $time);
			test_done;
		end
	endtask
	// Read data land at the edge where waitrequest is seen low
	always @(posedge sys_clk)
		if (req.read && waitreq === 1'b0)
			chk8(rdata, (expq.size() > 0) ? expq.pop_front() : 8'hxx);
	// ==========================================
	// Avalon master: hold until waitrequest low, then one idle edge
	task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int n;
		req <= '{read: !wr, write: wr, address: a, writedata: d};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		limit(n, 50);
		req <= '0;
		@(posedge sys_clk);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		expq.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask
	task stop_wake(input logic [1:0] k, input logic s, input int n);
		int c;
		bus(1'b1, 4'h3, {7'h00, s});
		go <= 1'b1;
		kind <= k;
		@(posedge sys_clk);
		go <= 1'b0;
		c = 0;
		while (xtal_en !== 1'b0 && c < 20) begin
			@(posedge sys_clk);
			c++;
		end
		limit(c, 20);
		chk1(bus_en, 1'b0, "bus clock in stop");
		chk1(presc === 12'h000, 1'b1, "prescaler in stop");
		c = 0;
		while (xtal_en !== 1'b1 && c < 50) begin
			@(posedge sys_clk);
			c++;
		end
		limit(c, 50);
		c = 0;
		while (stack_go !== 1'b1 && c < 9000) begin
			@(posedge sys_clk);
			c++;
			if (c == 10) begin
				chk1(presc !== 12'h000, 1'b1, "prescaler counts");
				chk1(bus_en, 1'b0, "bus clock in recovery");
			end
		end
		limit(c, 9000);
		chk1(bus_en, 1'b1, "clock before stacking");
		chk1(c >= 2 * n - 4 && c <= 2 * n + 4, 1'b1, "recovery length");
	endtask
	// ==========================================
	// Stimulus
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		logic [7:0] d;
		void'($urandom(26997));
		{resetn, go, brk_state, kind} = '0;
		req = '0;
		cause = '0;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rd(4'h1, 8'h80);
		rd(4'h1, 8'h00);
		for (int i = 0; i < 6; i++) begin
			cause <= stpsq_cause_t'(6'h20 >> i);
			@(posedge sys_clk);
			cause <= '0;
			rd(4'h1, (i == 5) ? 8'h02 : 8'h80 >> i);
			rd(4'h1, 8'h00);
		end
		bus(1'b1, 4'hf, 8'($urandom));
		rd(4'hf, 8'h00);
		stop_wake(2'h0, 1'b1, 32);
		rd(4'h0, 8'h00);
		rd(4'h3, 8'h01);
		rd(4'h4, 8'h00);
		stop_wake(2'h1, 1'b0, 4096);
		rd(4'h0, 8'h02);
		rd(4'h0, 8'h02);
		bus(1'b1, 4'h0, 8'h00);
		rd(4'h0, 8'h00);
		stop_wake(2'h2, 1'b1, 32);
		d = 8'($urandom) & 8'h01;
		bus(1'b1, 4'h2, d);
		brk_state <= 1'b1;
		@(posedge sys_clk);
		@(posedge sys_clk);
		chk1(clr_ok, d[0], "clear enable in break");
		bus(1'b1, 4'h2, ~d & 8'h01);
		chk1(clr_ok, ~d[0], "clear enable in break");
		rd(4'h2, ~d & 8'h01);
		bus(1'b1, 4'h2, 8'h00);
		brk_state <= 1'b0;
		@(posedge sys_clk);
		@(posedge sys_clk);
		chk1(clr_ok, 1'b1, "clearing outside break");
		test_done;
	end
endmodule
